// ### logic/pss_pkg.sv
package pss_pkg;

	localparam int          ADDR_W        = 12;
	localparam int          DATA_W        = 32;
	localparam int          NUM_CNT       = 6;
	localparam int          PEND_WORDS    = 8;
	localparam int          IMG_WORDS     = 32;
	localparam int          IDX_W         = 5;

	// Register byte offsets
	localparam logic [11:0] CTRL_OFS      = 12'h000;
	localparam logic [11:0] STATUS_OFS    = 12'h004;
	localparam logic [11:0] FMASK_LO_OFS  = 12'h008;
	localparam logic [11:0] FMASK_HI_OFS  = 12'h00C;
	localparam logic [11:0] VALID_LO_OFS  = 12'h010;
	localparam logic [11:0] VALID_HI_OFS  = 12'h014;
	localparam logic [11:0] IDENT_LEN_OFS = 12'h018;
	localparam logic [11:0] IDENT_POS_OFS = 12'h01C;
	localparam logic [11:0] CBPTR_LO_OFS  = 12'h020;
	localparam logic [11:0] CBPTR_HI_OFS  = 12'h024;
	localparam logic [11:0] BASE_LO_OFS   = 12'h028;
	localparam logic [11:0] BASE_HI_OFS   = 12'h02C;
	localparam logic [11:0] HEAD_OFS      = 12'h030;
	localparam logic [11:0] LEN_OFS       = 12'h034;
	localparam logic [11:0] FILTER_OFS    = 12'h038;
	localparam logic [11:0] CNTMASK_OFS   = 12'h03C;
	localparam logic [11:0] PEND_OFS      = 12'h040;
	localparam logic [11:0] TALLY_OFS     = 12'h060;
	localparam logic [11:0] IMAGE_OFS     = 12'h100;
	localparam logic [11:0] IMAGE_END     = 12'h180;

	// Control and status bits
	localparam int          CTRL_SAVE_BIT = 0;
	localparam int          CTRL_REST_BIT = 1;
	localparam int          ST_BUSY_BIT   = 0;
	localparam int          ST_AVAIL_BIT  = 1;
	localparam int          ST_ENAB_BIT   = 2;

	// Feature bit, 62 of a 64-bit word, bit 30 of its upper half
	localparam int          FEAT_BIT      = 62;
	localparam int          FEAT_HI_BIT   = FEAT_BIT - DATA_W;

	// Identification answers
	localparam logic [31:0] IMG_LEN_BYTES = 32'h0000_0080;
	localparam logic [31:0] IMG_POS_BYTES = 32'h0000_0340;

	// Image word indices
	localparam logic [4:0]  W_CB_LO       = 5'h00;
	localparam logic [4:0]  W_CB_HI       = 5'h01;
	localparam logic [4:0]  W_FLAGS       = 5'h02;
	localparam logic [4:0]  W_HEAD        = 5'h03;
	localparam logic [4:0]  W_BASE_LO     = 5'h04;
	localparam logic [4:0]  W_BASE_HI     = 5'h05;
	localparam logic [4:0]  W_LEN         = 5'h06;
	localparam logic [4:0]  W_FILTER      = 5'h07;
	localparam logic [4:0]  W_PEND        = 5'h08;
	localparam logic [4:0]  W_TALLY       = 5'h10;
	localparam logic [4:0]  W_RSVD        = 5'h16;
	localparam logic [4:0]  W_LAST        = 5'h1F;

	localparam int          FLAG_LSB      = 1;
	localparam int          LEN_W         = 28;

	typedef enum logic [0:0] {
		PSS_IDLE = 1'b0,
		PSS_COPY = 1'b1
	} pss_state_t;

endpackage

// ### logic/pss_state_if.sv
`timescale 1ns/1ns
interface pss_state_if;
	logic [63:0] cbPtr;
	logic [63:0] ringBase;
	logic [31:0] ringHead;
	logic [27:0] ringLen;
	logic [31:0] filter;
	logic [5:0]  cntMask;
	logic [31:0] pend  [pss_pkg::PEND_WORDS];
	logic [31:0] tally [pss_pkg::NUM_CNT];
	logic [4:0]  wordIdx;
	logic [31:0] word;

	modport src (output cbPtr, ringBase, ringHead, ringLen, filter, cntMask, pend, tally, wordIdx, input word);
	modport gen (input cbPtr, ringBase, ringHead, ringLen, filter, cntMask, pend, tally, wordIdx, output word);
endinterface

// ### logic/pss_image_word.sv
`timescale 1ns/1ns
module pss_image_word (
	pss_state_if.gen st
);

	logic [4:0] off;

	always_comb begin
		off     = 5'h00;
		st.word = 32'h0000_0000;
		if (st.wordIdx == pss_pkg::W_CB_LO) begin
			st.word = st.cbPtr[31:0];
		end else if (st.wordIdx == pss_pkg::W_CB_HI) begin
			st.word = st.cbPtr[63:32];
		end else if (st.wordIdx == pss_pkg::W_FLAGS) begin
			st.word[pss_pkg::FLAG_LSB +: pss_pkg::NUM_CNT] = st.cntMask;
		end else if (st.wordIdx == pss_pkg::W_HEAD) begin
			st.word = st.ringHead;
		end else if (st.wordIdx == pss_pkg::W_BASE_LO) begin
			st.word = st.ringBase[31:0];
		end else if (st.wordIdx == pss_pkg::W_BASE_HI) begin
			st.word = st.ringBase[63:32];
		end else if (st.wordIdx == pss_pkg::W_LEN) begin
			st.word[pss_pkg::LEN_W-1:0] = st.ringLen;
		end else if (st.wordIdx == pss_pkg::W_FILTER) begin
			st.word = st.filter;
		end else if (st.wordIdx >= pss_pkg::W_PEND && st.wordIdx < pss_pkg::W_TALLY) begin
			off     = st.wordIdx - pss_pkg::W_PEND;
			st.word = st.pend[off[2:0]];
		end else if (st.wordIdx >= pss_pkg::W_TALLY && st.wordIdx < pss_pkg::W_RSVD) begin
			off     = st.wordIdx - pss_pkg::W_TALLY;
			st.word = st.tally[off[2:0]];
		end
		// Remaining words stay zero
	end

endmodule

// ### logic/pss_profiler_save.sv
`timescale 1ns/1ns
// What this block does
// - Feature mask bit 62 marks profiler available
// - Identification query reports image length, offset
// - Image is 128 bytes at offset 832
// - Reserved image fields hold zero
// - Bytes 7-0 hold control block pointer
// - Bytes 11-8 hold active counter flags
// - Head position and ring base in image
// - Ring length in 27:0, top bits zero
// - Bytes 31-28 hold the filter word
// - Bytes 63-32 hold pending record slot
// - Bytes 67-64 hold first event tally
// - Bytes 87-68 hold tallies two to six
// - Bytes 127-88 reserved, held zero
// - Disabled save stores nothing, clears bit 62
// - Enabled save copies raw state, sets 62
// - Empty-image restore zeroes and disables profiler
module pss_profiler_save (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	pss_state_if st ();

	pss_image_word u_word (
		.st (st)
	);

	pss_pkg::pss_state_t state_q,    state_d;
	logic [4:0]          idx_q,      idx_d;
	logic [63:0]         featMask_q, featMask_d;
	logic [63:0]         valid_q,    valid_d;
	logic [63:0]         cbPtr_q,    cbPtr_d;
	logic [63:0]         ringBase_q, ringBase_d;
	logic [31:0]         ringHead_q, ringHead_d;
	logic [27:0]         ringLen_q,  ringLen_d;
	logic [31:0]         filter_q,   filter_d;
	logic [5:0]          cntMask_q,  cntMask_d;
	logic [31:0]         pend_q      [pss_pkg::PEND_WORDS];
	logic [31:0]         pend_d      [pss_pkg::PEND_WORDS];
	logic [31:0]         tally_q     [pss_pkg::NUM_CNT];
	logic [31:0]         tally_d     [pss_pkg::NUM_CNT];
	logic [31:0]         image_q     [pss_pkg::IMG_WORDS];
	logic [31:0]         image_d     [pss_pkg::IMG_WORDS];
	logic [31:0]         prdata_q,   prdata_d;
	logic                pready_q,   pready_d;
	logic                pslverr_q,  pslverr_d;

	logic                setup;
	logic                wrDone;
	logic                busy;

	function automatic logic inRange(input logic [11:0] a, input logic [11:0] lo, input int words);
		return (a >= lo) && (a < lo + 12'(words * 4));
	endfunction

	function automatic logic [2:0] slot(input logic [11:0] a, input logic [11:0] lo);
		logic [11:0] d;
		d = a - lo;
		return d[4:2];
	endfunction

	function automatic logic isMapped(input logic [11:0] a);
		return (a[1:0] == 2'b00) &&
			(a < pss_pkg::PEND_OFS ||
			inRange(a, pss_pkg::PEND_OFS, pss_pkg::PEND_WORDS) ||
			inRange(a, pss_pkg::TALLY_OFS, pss_pkg::NUM_CNT) ||
			inRange(a, pss_pkg::IMAGE_OFS, pss_pkg::IMG_WORDS));
	endfunction

	// One wait state: pready rises the cycle after the access phase starts
	assign setup  = psel && penable && !pready_q;
	assign wrDone = psel && penable && pready_q && pwrite;
	assign busy   = (state_q == pss_pkg::PSS_COPY);

	// Live state towards the image word generator
	always_comb begin
		st.cbPtr    = cbPtr_q;
		st.ringBase = ringBase_q;
		st.ringHead = ringHead_q;
		st.ringLen  = ringLen_q;
		st.filter   = filter_q;
		st.cntMask  = cntMask_q;
		st.pend     = pend_q;
		st.tally    = tally_q;
		st.wordIdx  = idx_q;
	end

	// Bus answer
	always_comb begin
		pready_d  = setup;
		pslverr_d = setup && !isMapped(paddr);
		prdata_d  = 32'h0000_0000;
		if (setup && !pwrite && isMapped(paddr)) begin
			if (inRange(paddr, pss_pkg::PEND_OFS, pss_pkg::PEND_WORDS)) begin
				prdata_d = pend_q[slot(paddr, pss_pkg::PEND_OFS)];
			end else if (inRange(paddr, pss_pkg::TALLY_OFS, pss_pkg::NUM_CNT)) begin
				prdata_d = tally_q[slot(paddr, pss_pkg::TALLY_OFS)];
			end else if (inRange(paddr, pss_pkg::IMAGE_OFS, pss_pkg::IMG_WORDS)) begin
				prdata_d = image_q[paddr[6:2]];
			end else begin
				unique case (paddr)
					pss_pkg::STATUS_OFS: begin
						prdata_d[pss_pkg::ST_BUSY_BIT]  = busy;
						prdata_d[pss_pkg::ST_AVAIL_BIT] = featMask_q[pss_pkg::FEAT_BIT];
						prdata_d[pss_pkg::ST_ENAB_BIT]  = (cbPtr_q != 64'h0);
					end
					pss_pkg::FMASK_LO_OFS:  prdata_d = featMask_q[31:0];
					pss_pkg::FMASK_HI_OFS:  prdata_d = featMask_q[63:32];
					pss_pkg::VALID_LO_OFS:  prdata_d = valid_q[31:0];
					pss_pkg::VALID_HI_OFS:  prdata_d = valid_q[63:32];
					pss_pkg::IDENT_LEN_OFS: prdata_d = pss_pkg::IMG_LEN_BYTES;
					pss_pkg::IDENT_POS_OFS: prdata_d = pss_pkg::IMG_POS_BYTES;
					pss_pkg::CBPTR_LO_OFS:  prdata_d = cbPtr_q[31:0];
					pss_pkg::CBPTR_HI_OFS:  prdata_d = cbPtr_q[63:32];
					pss_pkg::BASE_LO_OFS:   prdata_d = ringBase_q[31:0];
					pss_pkg::BASE_HI_OFS:   prdata_d = ringBase_q[63:32];
					pss_pkg::HEAD_OFS:      prdata_d = ringHead_q;
					pss_pkg::LEN_OFS:       prdata_d[pss_pkg::LEN_W-1:0] = ringLen_q;
					pss_pkg::FILTER_OFS:    prdata_d = filter_q;
					pss_pkg::CNTMASK_OFS:   prdata_d[pss_pkg::FLAG_LSB +: pss_pkg::NUM_CNT] = cntMask_q;
					default:                prdata_d = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// Profiler state, save sequencer and restore of an empty image
	always_comb begin
		state_d    = state_q;
		idx_d      = idx_q;
		featMask_d = featMask_q;
		valid_d    = valid_q;
		cbPtr_d    = cbPtr_q;
		ringBase_d = ringBase_q;
		ringHead_d = ringHead_q;
		ringLen_d  = ringLen_q;
		filter_d   = filter_q;
		cntMask_d  = cntMask_q;
		pend_d     = pend_q;
		tally_d    = tally_q;
		unique case (state_q)
			pss_pkg::PSS_IDLE: begin
				// State is frozen during a copy so the image stays coherent
				if (wrDone) begin
					if (inRange(paddr, pss_pkg::PEND_OFS, pss_pkg::PEND_WORDS)) begin
						pend_d[slot(paddr, pss_pkg::PEND_OFS)] = pwdata;
					end else if (inRange(paddr, pss_pkg::TALLY_OFS, pss_pkg::NUM_CNT)) begin
						tally_d[slot(paddr, pss_pkg::TALLY_OFS)] = pwdata;
					end else begin
						unique case (paddr)
							pss_pkg::FMASK_LO_OFS: featMask_d[31:0]  = pwdata;
							pss_pkg::FMASK_HI_OFS: featMask_d[63:32] = pwdata;
							pss_pkg::VALID_LO_OFS: valid_d[31:0]     = pwdata;
							pss_pkg::VALID_HI_OFS: valid_d[63:32]    = pwdata;
							pss_pkg::CBPTR_LO_OFS: cbPtr_d[31:0]     = pwdata;
							pss_pkg::CBPTR_HI_OFS: cbPtr_d[63:32]    = pwdata;
							pss_pkg::BASE_LO_OFS:  ringBase_d[31:0]  = pwdata;
							pss_pkg::BASE_HI_OFS:  ringBase_d[63:32] = pwdata;
							pss_pkg::HEAD_OFS:     ringHead_d        = pwdata;
							pss_pkg::LEN_OFS:      ringLen_d         = pwdata[pss_pkg::LEN_W-1:0];
							pss_pkg::FILTER_OFS:   filter_d          = pwdata;
							pss_pkg::CNTMASK_OFS:  cntMask_d = pwdata[pss_pkg::FLAG_LSB +: pss_pkg::NUM_CNT];
							pss_pkg::CTRL_OFS: begin
								if (pwdata[pss_pkg::CTRL_SAVE_BIT] && featMask_q[pss_pkg::FEAT_BIT]) begin
									if (cbPtr_q == 64'h0) begin
										valid_d[pss_pkg::FEAT_BIT] = 1'b0;
									end else begin
										state_d = pss_pkg::PSS_COPY;
										idx_d   = 5'h00;
									end
								end else if (pwdata[pss_pkg::CTRL_REST_BIT] && featMask_q[pss_pkg::FEAT_BIT] &&
									!valid_q[pss_pkg::FEAT_BIT]) begin
									cbPtr_d    = 64'h0;
									ringBase_d = 64'h0;
									ringHead_d = 32'h0000_0000;
									ringLen_d  = '0;
									filter_d   = 32'h0000_0000;
									cntMask_d  = '0;
									for (int i = 0; i < pss_pkg::PEND_WORDS; i++) begin
										pend_d[i] = 32'h0000_0000;
									end
									for (int i = 0; i < pss_pkg::NUM_CNT; i++) begin
										tally_d[i] = 32'h0000_0000;
									end
								end
							end
							default: ;
						endcase
					end
				end
			end
			pss_pkg::PSS_COPY: begin
				idx_d = idx_q + 5'h01;
				if (idx_q == pss_pkg::W_LAST) begin
					state_d                    = pss_pkg::PSS_IDLE;
					valid_d[pss_pkg::FEAT_BIT] = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q    <= pss_pkg::PSS_IDLE;
			idx_q      <= 5'h00;
			featMask_q <= 64'h0;
			valid_q    <= 64'h0;
			cbPtr_q    <= 64'h0;
			ringBase_q <= 64'h0;
			ringHead_q <= 32'h0000_0000;
			ringLen_q  <= '0;
			filter_q   <= 32'h0000_0000;
			cntMask_q  <= '0;
			for (int i = 0; i < pss_pkg::PEND_WORDS; i++) begin
				pend_q[i] <= 32'h0000_0000;
			end
			for (int i = 0; i < pss_pkg::NUM_CNT; i++) begin
				tally_q[i] <= 32'h0000_0000;
			end
		end else begin
			state_q    <= state_d;
			idx_q      <= idx_d;
			featMask_q <= featMask_d;
			valid_q    <= valid_d;
			cbPtr_q    <= cbPtr_d;
			ringBase_q <= ringBase_d;
			ringHead_q <= ringHead_d;
			ringLen_q  <= ringLen_d;
			filter_q   <= filter_d;
			cntMask_q  <= cntMask_d;
			pend_q     <= pend_d;
			tally_q    <= tally_d;
		end
	end

	// Image store: one word per cycle, raw copy with no checks
	always_comb begin
		image_d = image_q;
		if (busy) begin
			image_d[idx_q] = st.word;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < pss_pkg::IMG_WORDS; i++) begin
				image_q[i] <= 32'h0000_0000;
			end
		end else begin
			image_q <= image_d;
		end
	end

endmodule

// ### tb/pss_save_area_mem.sv
`timescale 1ns/1ns
// Slice of system memory that receives the profiler image
module pss_save_area_mem (
	input  wire logic        sys_clk,
	input  wire logic        wrEn,
	input  wire logic [4:0]  wrIdx,
	input  wire logic [31:0] wrData,
	input  wire logic [4:0]  rdIdx,
	output logic      [31:0] rdData
);
	logic [31:0] mem [32];
	// Poisoned so a missed store never reads back as zero
	initial for (int i = 0; i < 32; i++) mem[i] = 32'hDEAD_BEEF;
	// Plain always: the poison fill above is a second writer of mem
	always @(posedge sys_clk) if (wrEn) mem[wrIdx] <= wrData;
	assign rdData = mem[rdIdx];
endmodule

// ### tb/pss_profiler_save_sva.sv
`timescale 1ns/1ns
module pss_profiler_save_sva (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_acc; psel && penable && !pready; endsequence
	sequence s_rd(logic [11:0] a); pready && !pwrite && paddr == a; endsequence
	sequence s_rsvd; pready && !pwrite && paddr >= 12'h158 && paddr < pss_pkg::IMAGE_END; endsequence
	property p_one_wait; s_acc |=> pready; endproperty
	a_one_wait: assert property (p_one_wait) else $error("pready late");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready held");
	property p_err_ready; pslverr |-> pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
	property p_idle_data; !pready |-> prdata == 32'h0; endproperty
	a_idle_data: assert property (p_idle_data) else $error("prdata not zero");
	property p_len; s_rd(pss_pkg::IDENT_LEN_OFS) |-> prdata == 32'h0000_0080; endproperty
	a_len: assert property (p_len) else $error("image length wrong");
	property p_pos; s_rd(pss_pkg::IDENT_POS_OFS) |-> prdata == 32'h0000_0340; endproperty
	a_pos: assert property (p_pos) else $error("image offset wrong");
	property p_rsvd; s_rsvd |-> prdata == 32'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved word set");
	property p_len_top; s_rd(12'h118) |-> prdata[31:28] == 4'h0; endproperty
	a_len_top: assert property (p_len_top) else $error("length top bits set");
	property p_flags; s_rd(12'h108) |-> prdata[31:7] == 25'h0 && !prdata[0]; endproperty
	a_flags: assert property (p_flags) else $error("flag word reserved bits set");
endmodule
bind pss_profiler_save pss_profiler_save_sva pss_profiler_save_sva_i (.sys_clk, .rst, .paddr, .psel,
	.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);

// ### tb/pss_profiler_save_test.sv
`timescale 1ns/1ns
module pss_profiler_save_test;
	logic        sys_clk;
	logic        rst;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        memWr;
	logic [4:0]  memWrIdx;
	logic [31:0] memWrData;
	logic [4:0]  memRdIdx;
	logic [31:0] memRdData;
	logic [31:0] r;
	logic        lastErr;
	logic [31:0] expImg [32];
	int          mismatches;
	int          num_checks;
	int          n;

	pss_profiler_save pss_profiler_save_i (.sys_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr);
	pss_save_area_mem pss_save_area_mem_i (.sys_clk, .wrEn(memWr), .wrIdx(memWrIdx), .wrData(memWrData),
		.rdIdx(memRdIdx), .rdData(memRdData));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chkFlag(input logic got, input logic exp, input string msg);
		chk({31'h0, got}, {31'h0, exp}, msg);
	endtask

	// One idle edge after release keeps psel from being driven twice in a time step
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge sys_clk);
			k++;
		end
		if (k >= 20)
			chkFlag(1'b0, 1'b1, "no pready");
		r = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task automatic rd(input logic [11:0] a);
		xfer(a, 1'b0, 32'h0);
	endtask

	function automatic logic [31:0] pat(input int k);
		return 32'hF1E2_D3C4 ^ (32'(k) * 32'h0109_0A0B);
	endfunction

	function automatic logic [11:0] regOf(input int k);
		logic [11:0] fixedAddr [8];
		fixedAddr = '{pss_pkg::CBPTR_LO_OFS, pss_pkg::CBPTR_HI_OFS, pss_pkg::CNTMASK_OFS, pss_pkg::HEAD_OFS,
			pss_pkg::BASE_LO_OFS, pss_pkg::BASE_HI_OFS, pss_pkg::LEN_OFS, pss_pkg::FILTER_OFS};
		return (k < 8) ? fixedAddr[k] : pss_pkg::PEND_OFS + 12'(4 * (k - 8));
	endfunction

	initial begin
		repeat (20000) @(posedge sys_clk);
		chkFlag(1'b0, 1'b1, "watchdog expired");
		tally_and_finish();
	end

	initial begin
		{rst, psel, penable, pwrite, memWr} = 5'h1F;
		{psel, penable, pwrite, memWr} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		memWrIdx = 5'h00;
		memWrData = 32'h0;
		memRdIdx = 5'h00;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(pss_pkg::IDENT_LEN_OFS);
		chk(r, 32'h0000_0080, "image length");
		chkFlag(lastErr, 1'b0, "mapped read error");
		rd(pss_pkg::IDENT_POS_OFS);
		chk(r, 32'h0000_0340, "image offset");
		rd(pss_pkg::STATUS_OFS);
		chk(r, 32'h0, "status after reset");
		wr(pss_pkg::VALID_HI_OFS, 32'h4000_0000);
		wr(pss_pkg::CTRL_OFS, 32'h1);
		rd(pss_pkg::VALID_HI_OFS);
		chk(r, 32'h4000_0000, "save without feature");
		wr(pss_pkg::FMASK_HI_OFS, 32'h4000_0000);
		rd(pss_pkg::STATUS_OFS);
		chk(r, 32'h0000_0002, "available flag");
		$display("test identification done");
		wr(pss_pkg::VALID_HI_OFS, 32'h4000_0000);
		wr(pss_pkg::CTRL_OFS, 32'h1);
		rd(pss_pkg::VALID_HI_OFS);
		chk(r, 32'h0, "valid bit after disabled save");
		rd(pss_pkg::IMAGE_OFS);
		chk(r, 32'h0, "image untouched");
		$display("test disabled save done");
		for (int k = 0; k < 32; k++) begin
			expImg[k] = (k < 22) ? pat(k) : 32'h0;
			if (k < 22)
				wr(regOf(k), pat(k));
		end
		// Mask sits in bits 6:1, length keeps only 27:0
		expImg[2] = pat(2) & 32'h0000_007E;
		expImg[6] = pat(6) & 32'h0FFF_FFFF;
		wr(pss_pkg::CTRL_OFS, 32'h1);
		// Lands mid-copy and must be dropped
		wr(pss_pkg::CBPTR_LO_OFS, 32'h0000_0000);
		rd(pss_pkg::STATUS_OFS);
		chkFlag(r[pss_pkg::ST_BUSY_BIT], 1'b1, "busy during copy");
		n = 0;
		while (r[pss_pkg::ST_BUSY_BIT] !== 1'b0 && n < 40) begin
			rd(pss_pkg::STATUS_OFS);
			n++;
		end
		chk(r, 32'h0000_0006, "status after save");
		rd(pss_pkg::VALID_HI_OFS);
		chk(r, 32'h4000_0000, "valid bit after save");
		rd(pss_pkg::CBPTR_LO_OFS);
		chk(r, pat(0), "write during copy dropped");
		wr(pss_pkg::CTRL_OFS, 32'h2);
		rd(pss_pkg::CBPTR_HI_OFS);
		chk(r, pat(1), "restore with valid image keeps state");
		for (int k = 0; k < 32; k++) begin
			rd(pss_pkg::IMAGE_OFS + 12'(4 * k));
			memWr <= 1'b1;
			memWrIdx <= 5'(k);
			memWrData <= r;
			@(posedge sys_clk);
			memWr <= 1'b0;
		end
		for (int k = 0; k < 32; k++) begin
			memRdIdx = 5'(k);
			#1;
			chk(memRdData, expImg[k], "saved image word");
		end
		$display("test enabled save done");
		rd(12'h0F0);
		chkFlag(lastErr, 1'b1, "unmapped read error");
		wr(12'h002, 32'h1);
		chkFlag(lastErr, 1'b1, "unaligned write error");
		$display("test errors done");
		wr(pss_pkg::VALID_HI_OFS, 32'h0);
		wr(pss_pkg::CTRL_OFS, 32'h2);
		rd(pss_pkg::CBPTR_LO_OFS);
		chk(r, 32'h0, "pointer low after empty restore");
		rd(pss_pkg::CBPTR_HI_OFS);
		chk(r, 32'h0, "pointer high after empty restore");
		rd(pss_pkg::STATUS_OFS);
		chk(r, 32'h0000_0002, "profiler disabled");
		$display("test empty restore done");
		tally_and_finish();
	end
endmodule
